// File: src/uils_top.sv
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module uils_top (
	input  wire logic                   CLK,
	input  wire logic                   RESET,
	input  wire logic                   HSEL,
	input  wire logic [31:0]            HADDR,
	input  wire logic [1:0]             HTRANS,
	input  wire logic                   HWRITE,
	input  wire logic [2:0]             HSIZE,
	input  wire logic [31:0]            HWDATA,
	input  wire logic                   HREADY,
	output logic      [31:0]            HRDATA,
	output logic                        HREADYOUT,
	output logic                        HRESP,
	input  wire uils_pkg::uils_rx_stat_t RX_STAT,
	input  wire uils_pkg::uils_tx_stat_t TX_STAT,
	input  wire logic                   FIFO_ENABLE,
	input  wire logic [3:0]             INTERRUPT_MASK,
	input  wire logic                   MODEM_CHANGE,
	input  wire logic                   TX_SHIFT_BIT,
	input  wire logic                   BUS_MODE_68,
	output uils_pkg::uils_fmt_t         LINE_FORMAT,
	output logic                        RX_PUSH,
	output logic                        TX_LINE,
	output logic                        TERMINAL_READY_N,
	output logic                        REQUEST_TO_SEND_N,
	output logic                        USER_OUTPUT_ONE_N,
	output logic                        USER_OUTPUT_TWO_N,
	output logic                        LOOP_RING_INDICATOR_N,
	output logic                        LOOP_CARRIER_DETECT_N,
	output logic                        LOOPBACK,
	output logic                        IRQ_OUT,
	output logic                        IRQ_OE_N
);
	typedef enum logic [2:0] {SRC_NONE, SRC_LINE, SRC_RX, SRC_TMO, SRC_TX, SRC_MDM} uils_src_t;

	logic [7:0]  fmt_r;
	logic [7:0]  modem_r;
	logic        wr_pend_r;
	logic [1:0]  wr_idx_r;
	logic        acc_ok;
	logic        rd_id;
	logic        rd_ls;
	logic        wr_fmt;
	logic        wr_mdm;
	logic [1:0]  acc_idx;
	logic [7:0]  fmt_view;
	logic [7:0]  modem_view;
	logic        overrun_r;
	logic        perr_r;
	logic        ferr_r;
	logic        brk_r;
	logic        fifo_err_r;
	logic        thre_r;
	logic        thre_d_r;
	logic        thre_pend_r;
	logic        ls_pend_r;
	logic        mdm_pend_r;
	logic        brk_seen_r;
	logic        push_now;
	logic        rx_err_evt;
	logic        tx_empty_flag;
	logic        thre_flag;
	logic [2:0]  mode_sync_r;
	logic        mode68_r;
	uils_src_t   src;
	logic [5:0]  id_code;
	logic [7:0]  id_val;
	logic [7:0]  ls_val;
	logic        irq_nxt;

	// Register access. Reads are answered without wait states, so the slave never stalls.
	assign acc_ok  = HSEL && HREADY && (HTRANS == uils_pkg::HTRANS_NONSEQ);
	assign acc_idx = HADDR[uils_pkg::ADDR_MSB:uils_pkg::ADDR_LSB];
	assign rd_id   = acc_ok && !HWRITE && (acc_idx == uils_pkg::OFS_INT_ID[3:2]);
	assign rd_ls   = acc_ok && !HWRITE && (acc_idx == uils_pkg::OFS_LINE_STAT[3:2]);
	assign wr_fmt  = wr_pend_r && (wr_idx_r == uils_pkg::OFS_LINE_FMT[3:2]);
	assign wr_mdm  = wr_pend_r && (wr_idx_r == uils_pkg::OFS_MODEM_CTL[3:2]);

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			wr_pend_r <= 1'b0;
			wr_idx_r  <= 2'h0;
		end else begin
			wr_pend_r <= acc_ok && HWRITE;
			wr_idx_r  <= acc_idx;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			fmt_r   <= uils_pkg::FMT_RESET;
			modem_r <= uils_pkg::MODEM_RESET;
		end else begin
			if (wr_fmt)
				fmt_r <= HWDATA[7:0] & uils_pkg::LF_MASK;
			if (wr_mdm)
				modem_r <= HWDATA[7:0] & uils_pkg::MC_MASK;
		end
	end

	// A read that follows a write to the same register sees the new value.
	assign fmt_view   = wr_fmt ? (HWDATA[7:0] & uils_pkg::LF_MASK) : fmt_r;
	assign modem_view = wr_mdm ? (HWDATA[7:0] & uils_pkg::MC_MASK) : modem_r;

	// Bus mode strap comes from a pin and is taken only once two stages agree.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			mode_sync_r <= 3'h0;
			mode68_r    <= 1'b0;
		end else begin
			mode_sync_r <= {mode_sync_r[1:0], BUS_MODE_68};
			if (mode_sync_r[1] == mode_sync_r[2])
				mode68_r <= mode_sync_r[2];
		end
	end

	// Receive side status.
	assign push_now   = RX_STAT.char_done && !RX_STAT.fifo_full &&
	                    !(RX_STAT.brk && brk_seen_r);
	assign rx_err_evt = RX_STAT.char_done &&
	                    (RX_STAT.parity_err || RX_STAT.frame_err || RX_STAT.brk);

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			RX_PUSH    <= 1'b0;
			brk_seen_r <= 1'b0;
		end else begin
			RX_PUSH <= push_now;
			if (RX_STAT.char_done)
				brk_seen_r <= RX_STAT.brk && FIFO_ENABLE;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			overrun_r  <= 1'b0;
			perr_r     <= 1'b0;
			ferr_r     <= 1'b0;
			brk_r      <= 1'b0;
			fifo_err_r <= 1'b0;
		end else begin
			// A new event in the same cycle as the status read survives the read.
			overrun_r <= (RX_STAT.char_done && RX_STAT.fifo_full) ||
			             (overrun_r && !rd_ls);
			if (RX_STAT.char_done && !RX_STAT.fifo_full) begin
				perr_r <= RX_STAT.parity_err;
				ferr_r <= RX_STAT.frame_err;
				brk_r  <= RX_STAT.brk;
			end else if (rd_ls) begin
				perr_r <= 1'b0;
				ferr_r <= 1'b0;
				brk_r  <= 1'b0;
			end
			fifo_err_r <= (rx_err_evt && FIFO_ENABLE && push_now) ||
			              (fifo_err_r && !rd_ls);
		end
	end

	// Transmit side status.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			thre_r <= 1'b1;
		end else if (TX_STAT.load) begin
			thre_r <= 1'b1;
		end else if (TX_STAT.host_write) begin
			thre_r <= 1'b0;
		end
	end

	assign thre_flag     = FIFO_ENABLE ? TX_STAT.fifo_empty : thre_r;
	assign tx_empty_flag = thre_flag && !TX_STAT.shift_busy;

	// Interrupt sources with their own pending latches.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			thre_d_r    <= 1'b1;
			thre_pend_r <= 1'b0;
			ls_pend_r   <= 1'b0;
			mdm_pend_r  <= 1'b0;
		end else begin
			thre_d_r    <= thre_flag;
			thre_pend_r <= (thre_flag && !thre_d_r) ||
			               (thre_pend_r && !TX_STAT.host_write &&
			               !(rd_id && src == SRC_TX));
			ls_pend_r   <= rx_err_evt || (RX_STAT.char_done && RX_STAT.fifo_full) ||
			               (ls_pend_r && !rd_ls && !(rd_id && src == SRC_LINE));
			mdm_pend_r  <= MODEM_CHANGE ||
			               (mdm_pend_r && !(rd_id && src == SRC_MDM));
		end
	end

	// Masking comes first so a disabled source never hides an enabled one.
	always_comb begin
		src = SRC_NONE;
		if (ls_pend_r && INTERRUPT_MASK[uils_pkg::IM_LINE])
			src = SRC_LINE;
		else if (RX_STAT.timeout && INTERRUPT_MASK[uils_pkg::IM_RX])
			src = SRC_TMO;
		else if (RX_STAT.trigger && INTERRUPT_MASK[uils_pkg::IM_RX])
			src = SRC_RX;
		else if (thre_pend_r && INTERRUPT_MASK[uils_pkg::IM_TX])
			src = SRC_TX;
		else if (mdm_pend_r && INTERRUPT_MASK[uils_pkg::IM_MDM])
			src = SRC_MDM;
	end

	always_comb begin
		unique case (src)
			SRC_LINE: id_code = uils_pkg::ID_LINE_STAT;
			SRC_RX:   id_code = uils_pkg::ID_RX_READY;
			SRC_TMO:  id_code = uils_pkg::ID_RX_TIMEOUT;
			SRC_TX:   id_code = uils_pkg::ID_TX_EMPTY;
			SRC_MDM:  id_code = uils_pkg::ID_MODEM;
			SRC_NONE: id_code = uils_pkg::ID_NONE;
			default:  id_code = uils_pkg::ID_NONE;
		endcase
	end

	assign id_val = {{2{FIFO_ENABLE}}, id_code};
	assign ls_val = {fifo_err_r, tx_empty_flag, thre_flag,
	                 FIFO_ENABLE ? RX_STAT.head_brk : brk_r,
	                 FIFO_ENABLE ? RX_STAT.head_frame_err : ferr_r,
	                 FIFO_ENABLE ? RX_STAT.head_parity_err : perr_r,
	                 overrun_r, RX_STAT.held};

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			HRDATA    <= 32'h0;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else if (acc_ok && !HWRITE) begin
			unique case (acc_idx)
				uils_pkg::OFS_INT_ID[3:2]:    HRDATA <= {24'h0, id_val};
				uils_pkg::OFS_LINE_FMT[3:2]:  HRDATA <= {24'h0, fmt_view};
				uils_pkg::OFS_MODEM_CTL[3:2]: HRDATA <= {24'h0, modem_view};
				uils_pkg::OFS_LINE_STAT[3:2]: HRDATA <= {24'h0, ls_val};
			endcase
		end
	end

	// Line format outputs to the shifters.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			LINE_FORMAT <= '0;
			LINE_FORMAT.stop_halves <= uils_pkg::STOP_ONE;
			TX_LINE     <= 1'b1;
		end else begin
			LINE_FORMAT.word_len <= fmt_r[uils_pkg::LF_LEN_HI:uils_pkg::LF_LEN_LO];
			if (!fmt_r[uils_pkg::LF_STOP])
				LINE_FORMAT.stop_halves <= uils_pkg::STOP_ONE;
			else if (fmt_r[uils_pkg::LF_LEN_HI:uils_pkg::LF_LEN_LO] == uils_pkg::LEN_FIVE)
				LINE_FORMAT.stop_halves <= uils_pkg::STOP_ONE_HALF;
			else
				LINE_FORMAT.stop_halves <= uils_pkg::STOP_TWO;
			LINE_FORMAT.par_en         <= fmt_r[uils_pkg::LF_PAR_EN];
			LINE_FORMAT.par_even       <= fmt_r[uils_pkg::LF_EVEN];
			LINE_FORMAT.par_force      <= fmt_r[uils_pkg::LF_FORCE];
			LINE_FORMAT.par_forced_val <= !fmt_r[uils_pkg::LF_EVEN];
			// Loopback keeps the pin idle unless break is set; break pulls the line low in every mode.
			if (fmt_r[uils_pkg::LF_BREAK])
				TX_LINE <= 1'b0;
			else if (modem_r[uils_pkg::MC_LOOP])
				TX_LINE <= 1'b1;
			else
				TX_LINE <= TX_SHIFT_BIT;
		end
	end

	// Modem outputs; in loopback the pins but user output one rest inactive; user output one, like the loop ring, is driven only in loopback.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			TERMINAL_READY_N      <= 1'b1;
			REQUEST_TO_SEND_N     <= 1'b1;
			USER_OUTPUT_ONE_N     <= 1'b1;
			USER_OUTPUT_TWO_N     <= 1'b1;
			LOOP_RING_INDICATOR_N <= 1'b1;
			LOOP_CARRIER_DETECT_N <= 1'b1;
			LOOPBACK              <= 1'b0;
		end else begin
			LOOPBACK <= modem_r[uils_pkg::MC_LOOP];
			TERMINAL_READY_N  <= !modem_r[uils_pkg::MC_TERM_RDY] ||
			                     modem_r[uils_pkg::MC_LOOP];
			REQUEST_TO_SEND_N <= !modem_r[uils_pkg::MC_REQ_SEND] ||
			                     modem_r[uils_pkg::MC_LOOP];
			USER_OUTPUT_ONE_N <= !(modem_r[uils_pkg::MC_USER_ONE] &&
			                     modem_r[uils_pkg::MC_LOOP]);
			USER_OUTPUT_TWO_N <= !modem_r[uils_pkg::MC_USER_TWO] ||
			                     modem_r[uils_pkg::MC_LOOP];
			LOOP_RING_INDICATOR_N <= !(modem_r[uils_pkg::MC_USER_ONE] &&
			                         modem_r[uils_pkg::MC_LOOP]);
			LOOP_CARRIER_DETECT_N <= !(modem_r[uils_pkg::MC_USER_TWO] &&
			                         modem_r[uils_pkg::MC_LOOP]);
		end
	end

	// Interrupt pin. Outside 68 mode and loopback the driver obeys the user output two bit.
	assign irq_nxt = (src != SRC_NONE);

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			IRQ_OUT  <= 1'b0;
			IRQ_OE_N <= 1'b1;
		end else begin
			IRQ_OUT  <= irq_nxt;
			IRQ_OE_N <= !(mode68_r || modem_r[uils_pkg::MC_LOOP] ||
			             modem_r[uils_pkg::MC_USER_TWO]);
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	sequence id_read_of(logic [5:0] code);
		rd_id && id_code == code;
	endsequence

	// With FIFO_ENABLE set, a break lasting several frames reports one character; later ones are held back.
	sequence break_char;
		RX_STAT.char_done && RX_STAT.brk && FIFO_ENABLE;
	endsequence

	id_code_read_a: assert property (rd_id |=> HRDATA[5:0] == $past(id_code))
		else $error("identification read returned wrong code");
	id_clear_line_a: assert property (id_read_of(uils_pkg::ID_LINE_STAT) and
		!rx_err_evt and !(RX_STAT.char_done && RX_STAT.fifo_full) |=> !ls_pend_r)
		else $error("line status source not cleared by read");
	id_keeps_tx_a: assert property (id_read_of(uils_pkg::ID_LINE_STAT) and thre_pend_r
		and !TX_STAT.host_write |=> thre_pend_r)
		else $error("lower source lost by identification read");
	id_none_bit_a: assert property (rd_id |=> HRDATA[0] == (HRDATA[5:1] == 5'h0 &&
		$past(src) == SRC_NONE))
		else $error("pending bit wrong");
	id_fifo_bits_a: assert property (rd_id |=> HRDATA[7:6] == {2{$past(FIFO_ENABLE)}})
		else $error("fifo bits wrong");
	stop_length_a: assert property (fmt_r[uils_pkg::LF_STOP] && fmt_r[1:0] != uils_pkg::LEN_FIVE
		|=> LINE_FORMAT.stop_halves == uils_pkg::STOP_TWO)
		else $error("stop length wrong");
	break_line_a: assert property (fmt_r[uils_pkg::LF_BREAK] |=> !TX_LINE)
		else $error("break does not hold line low");
	dtr_drive_a: assert property ($rose(modem_r[uils_pkg::MC_TERM_RDY]) &&
		!modem_r[uils_pkg::MC_LOOP] |=> !TERMINAL_READY_N)
		else $error("terminal ready not driven low");
	overrun_push_a: assert property (RX_STAT.char_done && RX_STAT.fifo_full |=>
		overrun_r && !RX_PUSH)
		else $error("overrun handling wrong");
	one_break_a: assert property (break_char ##1
		((FIFO_ENABLE && !(RX_STAT.char_done && !RX_STAT.brk)) throughout
		(##[0:300] break_char)) |=> !RX_PUSH)
		else $error("second break character pushed");
	tx_empty_a: assert property (rd_ls && TX_STAT.shift_busy |=> !HRDATA[6])
		else $error("transmitter empty while shifting");
	host_write_tx_a: assert property (TX_STAT.host_write |=> !thre_pend_r ||
		$rose(thre_pend_r))
		else $error("holding empty interrupt survives host write");
	irq_follow_a: assert property (src != SRC_NONE |=> IRQ_OUT)
		else $error("interrupt output not asserted");
endmodule : uils_top

// File: shared/uils_pkg.sv
package uils_pkg;
	// Register byte offsets on the AHB-Lite port.
	localparam logic [3:0] OFS_INT_ID     = 4'h0;
	localparam logic [3:0] OFS_LINE_FMT   = 4'h4;
	localparam logic [3:0] OFS_MODEM_CTL  = 4'h8;
	localparam logic [3:0] OFS_LINE_STAT  = 4'hc;
	localparam int         ADDR_LSB       = 2;
	localparam int         ADDR_MSB       = 3;

	// Interrupt identification codes, bits 5 to 0.
	localparam logic [5:0] ID_NONE        = 6'h01;
	localparam logic [5:0] ID_LINE_STAT   = 6'h06;
	localparam logic [5:0] ID_RX_READY    = 6'h04;
	localparam logic [5:0] ID_RX_TIMEOUT  = 6'h0c;
	localparam logic [5:0] ID_TX_EMPTY    = 6'h02;
	localparam logic [5:0] ID_MODEM       = 6'h00;

	// Line format control fields.
	localparam int LF_LEN_LO = 0;
	localparam int LF_LEN_HI = 1;
	localparam int LF_STOP   = 2;
	localparam int LF_PAR_EN = 3;
	localparam int LF_EVEN   = 4;
	localparam int LF_FORCE  = 5;
	localparam int LF_BREAK  = 6;
	localparam logic [7:0] LF_MASK  = 8'h7f;
	localparam logic [1:0] LEN_FIVE = 2'h0;

	// Modem output control fields.
	localparam int MC_TERM_RDY = 0;
	localparam int MC_REQ_SEND = 1;
	localparam int MC_USER_ONE = 2;
	localparam int MC_USER_TWO = 3;
	localparam int MC_LOOP     = 4;
	localparam logic [7:0] MC_MASK = 8'h1f;

	// Interrupt mask bits.
	localparam int IM_RX   = 0;
	localparam int IM_TX   = 1;
	localparam int IM_LINE = 2;
	localparam int IM_MDM  = 3;

	// Stop length in half bit times.
	localparam logic [2:0] STOP_ONE      = 3'h2;
	localparam logic [2:0] STOP_ONE_HALF = 3'h3;
	localparam logic [2:0] STOP_TWO      = 3'h4;

	localparam logic [7:0] FMT_RESET   = 8'h00;
	localparam logic [7:0] MODEM_RESET = 8'h00;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic char_done;
		logic parity_err;
		logic frame_err;
		logic brk;
		logic fifo_full;
		logic held;
		logic trigger;
		logic timeout;
		logic head_parity_err;
		logic head_frame_err;
		logic head_brk;
	} uils_rx_stat_t;

	typedef struct packed {
		logic load;
		logic host_write;
		logic shift_busy;
		logic fifo_empty;
	} uils_tx_stat_t;

	typedef struct packed {
		logic [1:0] word_len;
		logic [2:0] stop_halves;
		logic       par_en;
		logic       par_even;
		logic       par_force;
		logic       par_forced_val;
	} uils_fmt_t;
endpackage : uils_pkg

// File: test/uils_far_model.sv
`timescale 1ns/1ps
// Behavioural stand-in for the receive and transmit sections next to the status block.
module uils_far_model #(
	parameter int DEPTH = 1
) (
	input  wire logic               CLK,
	input  wire logic               RESET,
	input  wire logic               RX_PUSH,
	output uils_pkg::uils_rx_stat_t RX_STAT,
	output uils_pkg::uils_tx_stat_t TX_STAT,
	output logic                    TX_SHIFT_BIT
);
	logic [4:0] cnt_r;
	logic [2:0] head_r;
	logic [2:0] hd;
	logic       done_r, pe_r, fe_r, bi_r, pop_r, trig_r, tmo_r;
	logic       load_r, wr_r, hold_r, busy_r, shift_r;

	assign hd = head_r & {3{cnt_r != 5'h00}};
	assign RX_STAT = '{done_r, pe_r, fe_r, bi_r, cnt_r >= DEPTH, cnt_r != 5'h00,
		trig_r, tmo_r, hd[2], hd[1], hd[0]};
	assign TX_STAT = '{load_r, wr_r, busy_r, !hold_r};
	// The shifter idles at mark; a scenario pulls it low to see the line follow it.
	assign TX_SHIFT_BIT = shift_r;

	initial begin
		{done_r, pe_r, fe_r, bi_r, pop_r, trig_r, tmo_r, load_r, wr_r, hold_r, busy_r} = '0;
		shift_r = 1'b1;
	end

	task automatic shift(input logic b);
		@(posedge CLK);
		shift_r <= b;
	endtask : shift

	// The store only grows on the block's push, so a dropped overrun character never lands.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cnt_r <= 5'h00;
			head_r <= 3'h0;
		end else begin
			cnt_r <= cnt_r + 5'(RX_PUSH) - 5'(pop_r);
			if (RX_PUSH && cnt_r == 5'h00) begin
				head_r <= {pe_r, fe_r, bi_r};
			end
		end
	end

	task automatic rx_char(input logic pe, input logic fe, input logic bi);
		@(posedge CLK);
		done_r <= 1'b1;
		pe_r <= pe;
		fe_r <= fe;
		bi_r <= bi;
		@(posedge CLK);
		done_r <= 1'b0;
	endtask : rx_char

	task automatic pop;
		@(posedge CLK);
		pop_r <= 1'b1;
		@(posedge CLK);
		pop_r <= 1'b0;
	endtask : pop

	task automatic levels(input logic trig, input logic tmo);
		@(posedge CLK);
		trig_r <= trig;
		tmo_r <= tmo;
	endtask : levels

	// Kind 0 is a host write, 1 a move into the shifter, 2 the shifter finishing.
	task automatic tx_step(input int kind);
		@(posedge CLK);
		wr_r <= (kind == 0);
		load_r <= (kind == 1);
		hold_r <= (kind == 0) ? 1'b1 : (kind == 1) ? 1'b0 : hold_r;
		busy_r <= (kind == 1) ? 1'b1 : (kind == 2) ? 1'b0 : busy_r;
		@(posedge CLK);
		wr_r <= 1'b0;
		load_r <= 1'b0;
	endtask : tx_step
endmodule : uils_far_model

// File: test/tb_uils_top.sv
`timescale 1ns/1ps
module tb_uils_top;
	logic                    clk;
	logic                    reset;
	logic                    hsel;
	logic [31:0]             haddr;
	logic [1:0]              htrans;
	logic [2:0]              hsize;
	logic                    bus_mode_68;
	logic                    hwrite;
	logic [31:0]             hwdata;
	logic [31:0]             hrdata;
	logic                    hreadyout;
	logic                    hresp;
	uils_pkg::uils_rx_stat_t rx_stat;
	uils_pkg::uils_tx_stat_t tx_stat;
	logic                    fifo_enable;
	logic [3:0]              int_mask;
	logic                    modem_change;
	logic                    tx_shift_bit;
	uils_pkg::uils_fmt_t     lf;
	logic                    rx_push, tx_line, dtr_n, rts_n, op1_n, op2_n;
	logic                    ring_n, cd_n, loopback, irq, irq_oe_n;
	logic [31:0]             rd;
	int                      miscompares;
	int                      tests_run;

	uils_top i_uils_top (.CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .RX_STAT(rx_stat), .TX_STAT(tx_stat),
		.FIFO_ENABLE(fifo_enable), .INTERRUPT_MASK(int_mask), .MODEM_CHANGE(modem_change),
		.TX_SHIFT_BIT(tx_shift_bit), .BUS_MODE_68(bus_mode_68), .LINE_FORMAT(lf),
		.RX_PUSH(rx_push),
		.TX_LINE(tx_line), .TERMINAL_READY_N(dtr_n), .REQUEST_TO_SEND_N(rts_n),
		.USER_OUTPUT_ONE_N(op1_n), .USER_OUTPUT_TWO_N(op2_n), .LOOP_RING_INDICATOR_N(ring_n),
		.LOOP_CARRIER_DETECT_N(cd_n), .LOOPBACK(loopback), .IRQ_OUT(irq), .IRQ_OE_N(irq_oe_n));

	uils_far_model i_uils_far_model (.CLK(clk), .RESET(reset), .RX_PUSH(rx_push),
		.RX_STAT(rx_stat), .TX_STAT(tx_stat), .TX_SHIFT_BIT(tx_shift_bit));

	always #10 clk = ~clk;

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= uils_pkg::HTRANS_NONSEQ;
		haddr <= {24'h000000, a};
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
		bus(1'b0, a, 8'h00);
		chk($sformatf("register %h", a), {24'h000000, exp & m}, rd & {24'h000000, m});
	endtask : rdc

	// Registered outputs lag the register write by one edge; look mid-cycle after that.
	task automatic settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task automatic t_reset;
		chk("reset outputs", 13'b1011111110010, {hreadyout, hresp, tx_line, dtr_n, rts_n, op1_n,
			op2_n, ring_n, cd_n, loopback, irq, irq_oe_n, rx_push});
		rdc(8'h00, 8'h01, 8'hff);
		rdc(8'h04, 8'h00, 8'hff);
		rdc(8'h08, 8'h00, 8'hff);
		rdc(8'h0c, 8'h60, 8'hff);
		rdc(8'h10, 8'h01, 8'hff);
	endtask : t_reset

	task automatic t_format;
		for (int j = 0; j < 8; j++) begin
			bus(1'b1, 8'h04, 8'(j));
			settle;
			chk("length stop parity", {j[1:0], !j[2] ? uils_pkg::STOP_ONE : j[1:0] == 2'h0 ?
				uils_pkg::STOP_ONE_HALF : uils_pkg::STOP_TWO, 1'b0},
				{lf.word_len, lf.stop_halves, lf.par_en});
		end
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, 8'h04, 8'h08 | 8'(k << 4));
			settle;
			chk("parity mode", {1'b1, k[0], k[1]}, {lf.par_en, lf.par_even, lf.par_force});
			if (k[1]) begin
				chk("forced parity", !k[0], lf.par_forced_val);
			end
		end
		bus(1'b1, 8'h04, 8'hff);
		rdc(8'h04, 8'h7f, 8'hff);
		bus(1'b1, 8'h04, 8'h40);
		settle;
		chk("break line", 1'b0, tx_line);
		bus(1'b1, 8'h04, 8'h00);
		settle;
		chk("line after break", 1'b1, tx_line);
		i_uils_far_model.shift(1'b0);
		settle;
		chk("line follows shifter", 1'b0, tx_line);
		bus(1'b1, 8'h08, 8'h10);
		settle;
		chk("line in loopback", 1'b1, tx_line);
		bus(1'b1, 8'h08, 8'h00);
		i_uils_far_model.shift(1'b1);
	endtask : t_format

	task automatic t_modem;
		logic [7:0] mv [6] = '{8'h03, 8'h08, 8'h04, 8'h1c, 8'h10, 8'h00};
		logic [7:0] ev [6] = '{8'h3b, 8'he3, 8'hfb, 8'hd4, 8'hf7, 8'hfb};
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, 8'h08, mv[i]);
			settle;
			chk("modem outputs", ev[i], {dtr_n, rts_n, op1_n, op2_n, irq_oe_n, loopback,
				ring_n, cd_n});
		end
		bus(1'b1, 8'h08, 8'hff);
		rdc(8'h08, 8'h1f, 8'hff);
		bus(1'b1, 8'h08, 8'h00);
		bus_mode_68 <= 1'b1;
		repeat (3) settle();
		chk("68 mode driver", 1'b0, irq_oe_n);
		@(posedge clk);
		bus_mode_68 <= 1'b0;
		repeat (3) settle();
		chk("16 mode driver", 1'b1, irq_oe_n);
	endtask : t_modem

	task automatic modem_event;
		@(posedge clk);
		modem_change <= 1'b1;
		@(posedge clk);
		modem_change <= 1'b0;
	endtask : modem_event

	task automatic t_irq;
		@(posedge clk);
		int_mask <= 4'hf;
		i_uils_far_model.tx_step(0);
		i_uils_far_model.tx_step(1);
		i_uils_far_model.tx_step(2);
		i_uils_far_model.rx_char(1'b1, 1'b0, 1'b0);
		modem_event();
		settle;
		chk("irq pending", 1'b1, irq);
		rdc(8'h00, 8'h06, 8'hff);
		rdc(8'h00, 8'h02, 8'hff);
		rdc(8'h00, 8'h00, 8'hff);
		rdc(8'h00, 8'h01, 8'hff);
		settle;
		chk("irq idle", 1'b0, irq);
		i_uils_far_model.levels(1'b1, 1'b1);
		settle;
		rdc(8'h00, 8'h0c, 8'hff);
		i_uils_far_model.levels(1'b1, 1'b0);
		settle;
		rdc(8'h00, 8'h04, 8'hff);
		i_uils_far_model.levels(1'b0, 1'b0);
		i_uils_far_model.tx_step(0);
		i_uils_far_model.tx_step(1);
		i_uils_far_model.tx_step(2);
		i_uils_far_model.tx_step(0);
		settle;
		rdc(8'h00, 8'h01, 8'hff);
		@(posedge clk);
		int_mask <= 4'h0;
		modem_event();
		settle;
		chk("masked irq", 1'b0, irq);
		rdc(8'h00, 8'h01, 8'hff);
		i_uils_far_model.pop();
	endtask : t_irq

	task automatic tx_seq;
		i_uils_far_model.tx_step(0);
		settle;
		rdc(8'h0c, 8'h00, 8'h60);
		i_uils_far_model.tx_step(1);
		settle;
		rdc(8'h0c, 8'h20, 8'h60);
		i_uils_far_model.tx_step(2);
		settle;
		rdc(8'h0c, 8'h60, 8'h60);
	endtask : tx_seq

	task automatic t_status;
		bus(1'b0, 8'h0c, 8'h00);
		i_uils_far_model.rx_char(1'b0, 1'b1, 1'b0);
		settle;
		rdc(8'h0c, 8'h09, 8'h7f);
		rdc(8'h0c, 8'h01, 8'h7f);
		i_uils_far_model.rx_char(1'b0, 1'b0, 1'b0);
		settle;
		chk("stored characters", 5'h01, i_uils_far_model.cnt_r);
		rdc(8'h0c, 8'h03, 8'h7f);
		i_uils_far_model.pop();
		i_uils_far_model.rx_char(1'b0, 1'b0, 1'b1);
		settle;
		rdc(8'h0c, 8'h11, 8'h7f);
		i_uils_far_model.pop();
		tx_seq();
	endtask : t_status

	task automatic t_fifo;
		@(posedge clk);
		fifo_enable <= 1'b1;
		settle;
		rdc(8'h00, 8'hc1, 8'hff);
		i_uils_far_model.rx_char(1'b1, 1'b0, 1'b0);
		settle;
		rdc(8'h0c, 8'he5, 8'hff);
		rdc(8'h0c, 8'h65, 8'hff);
		i_uils_far_model.pop();
		settle;
		rdc(8'h0c, 8'h60, 8'hff);
		tx_seq();
		i_uils_far_model.rx_char(1'b0, 1'b0, 1'b1);
		settle;
		rdc(8'h0c, 8'hf1, 8'hff);
		i_uils_far_model.pop();
		i_uils_far_model.rx_char(1'b0, 1'b0, 1'b1);
		settle;
		chk("break characters", 5'h00, i_uils_far_model.cnt_r);
		rdc(8'h0c, 8'h60, 8'hff);
	endtask : t_fifo

	// The sequence needs about four hundred cycles; fifty times that means a hang.
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		final_report();
	end

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		{hsel, hwrite, modem_change, fifo_enable, bus_mode_68} = '0;
		{haddr, hwdata} = '0;
		htrans = 2'h0;
		hsize = 3'h0;
		int_mask = 4'h0;
		miscompares = 0;
		tests_run = 0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		t_reset();
		t_format();
		t_modem();
		t_irq();
		t_status();
		t_fifo();
		final_report();
	end
endmodule : tb_uils_top
